/* design/gct_pkg.sv */
// Purpose: Constants and carrier types for the gated count timer
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes: Control, gate and mode registers sit at offsets chosen locally
package gct_pkg;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_GATE = 12'h004;
	localparam logic [11:0] OFF_LOW = 12'h008;
	localparam logic [11:0] OFF_HIGH = 12'h00c;
	localparam logic [11:0] OFF_MODE = 12'h010;
	localparam logic [11:0] OFF_FLAG = 12'h014;
	localparam logic [11:0] IDX_ASSIGN = 12'hf52;
	localparam logic [13:0] ADDR_ASSIGN = 14'h3d48;
	localparam int CTRL_ON = 0;
	localparam int CTRL_WIDE = 1;
	localparam int CTRL_NOSYNC = 2;
	localparam int CTRL_XTAL = 3;
	localparam int CTRL_PS_LO = 4;
	localparam int CTRL_CS_LO = 6;
	localparam int GATE_EN = 7;
	localparam int ASSIGN_RUN = 4;
	localparam int MODE_SCS_LO = 0;
	localparam int MODE_IDLE = 2;
	localparam int MODE_DRIVE = 3;
	localparam int MODE_SLEEP = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] GATE_RESET = 8'h00;
	localparam logic [7:0] ASSIGN_MASK = 8'h03;
	localparam logic [1:0] CS_INSTR = 2'h0;
	localparam logic [1:0] CS_SYS = 2'h1;
	localparam logic [1:0] CS_EXT = 2'h2;
	localparam logic [1:0] SCS_SECONDARY = 2'h1;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	localparam logic [1:0] INSTR_DIV_M1 = 2'h3;
	typedef struct packed {
		logic unit1_this_counter;
		logic unit2_this_counter;
	} assign_route_t;
	typedef enum logic [2:0] {
		PM_RUN = 3'b001,
		PM_SECONDARY_RUN_MODE = 3'b010,
		PM_SECONDARY_IDLE_MODE = 3'b100
	} pm_state_t;
endpackage

/* design/gated_count_timer_core.sv */
// What this block does
// - Oscillator-clock flag reads 1 while system clock comes from crystal or count pin.
// - Assignment field routes this counter to capture units: 00 both, 01 unit one, 10 none.
// - Unused assignment bits ignore writes and read zero.
// - Sixteen-bit incrementing count reached through high and low byte registers.
// - Internal clock makes a timer advancing per instruction or system clock cycle, prescaled.
// - External source advances on each rising edge of the count input.
// - External source counted synchronized or unsynchronized per sync control bit.
// - Counting needs both count-on and gate enable bits.
// - While counting is enabled, crystal pins are inputs, direction ignored, port reads zero.
// - Clock select: 01 system, 00 instruction, 10 pin or crystal per enable.
// - Instruction clock rate is oscillator rate divided by four, then by prescaler.
// - Counter mode waits for a falling edge after enable, byte write or re-enable.
// - Wide mode: high address is a buffer loaded on each low byte read.
// - Wide mode: low byte write also loads high byte from buffer.
// - Wide mode: live high byte not directly accessible.
// - Wide mode: high byte buffer writes keep prescaler; low writes clear it.
// - Crystal oscillator starts with its enable and runs in all power modes.
// - Drive level bit: 1 higher drive, 0 minimum power.
// - System clock select 01 enters secondary run mode from crystal.
// - Sleep in secondary run with idle bit clear enters secondary idle.
// - Count rolls FFFF to 0000 and latches overflow flag, gated by enable.
// - Prescale field divides by 1, 2, 4 or 8.
// - Sync bit ignored with internal clock selected.
// Purpose: Gated 16-bit timer/counter with AXI4-Lite registers
// Assumes: ext_count_i and crystal_clk_i are synchronous samples of the clock
// Notes: Async counting is modelled as unfiltered edge use, no second domain
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module gated_count_timer_core (
	// Clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// AXI4-Lite write
	input wire logic [13:0] s_awaddr_i,
	input wire logic s_awvalid_i,
	output logic s_awready_o,
	input wire logic [31:0] s_wdata_i,
	input wire logic [3:0] s_wstrb_i,
	input wire logic s_wvalid_i,
	output logic s_wready_o,
	output logic [1:0] s_bresp_o,
	output logic s_bvalid_o,
	input wire logic s_bready_i,
	// AXI4-Lite read
	input wire logic [13:0] s_araddr_i,
	input wire logic s_arvalid_i,
	output logic s_arready_o,
	output logic [31:0] s_rdata_o,
	output logic [1:0] s_rresp_o,
	output logic s_rvalid_o,
	input wire logic s_rready_i,
	// Count sources and pins
	input wire logic ext_count_i,
	input wire logic crystal_clk_i,
	input wire logic [1:0] port_pin_i,
	input wire logic [1:0] port_c_direction_i,
	input wire logic sleep_i,
	// Status outputs
	output logic [1:0] port_read_o,
	output logic [1:0] pin_oe_n_o,
	output logic crystal_run_o,
	output logic osc_drive_level_o,
	output logic overflow_irq_o,
	output logic [2:0] power_mode_o,
	output logic [1:0] route_unit_o,
	output logic [15:0] count_o
);
	logic [7:0] ctrl_q;
	logic [7:0] gate_q;
	logic [1:0] assign_q;
	logic [4:0] mode_q;
	logic [15:0] cnt_q;
	logic [7:0] hbuf_q;
	logic [2:0] ps_q;
	logic [1:0] div_q;
	logic ext_q, ext_sync_q, armed_q, ovf_q, ovf_en_q;
	gct_pkg::pm_state_t pm_q;
	logic [13:0] awaddr_q, araddr_q;
	logic aw_have_q, w_have_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] cs;
	logic src_in;
	logic enabled, ext_sel, edge_rise, edge_fall, tick, pre_tick, inc;
	logic wr_go, wr_low, wr_high, rd_low, rd_go, ok_w, ok_r;
	logic [11:0] wa, ra;
	logic [7:0] wb;
	logic [2:0] ps_max;
	logic [7:0] rbyte;

	assign cs = ctrl_q[gct_pkg::CTRL_CS_LO +: 2];
	assign enabled = ctrl_q[gct_pkg::CTRL_ON] & gate_q[gct_pkg::GATE_EN];
	assign ext_sel = cs[1];
	// Crystal enable picks the crystal line over the count pin
	assign src_in = ctrl_q[gct_pkg::CTRL_XTAL] ? crystal_clk_i : ext_count_i;
	// Sync bit only matters for the external path
	// Synced edge is one stage late so it lasts a single cycle
	assign edge_rise = ext_sel & (ctrl_q[gct_pkg::CTRL_NOSYNC] ?
		(src_in & ~ext_q) : (ext_q & ~ext_sync_q));
	assign edge_fall = ctrl_q[gct_pkg::CTRL_NOSYNC] ? (~src_in & ext_q) :
		(~ext_q & ext_sync_q);
	always_comb begin
		unique case (cs)
			gct_pkg::CS_SYS: tick = 1'b1;
			gct_pkg::CS_INSTR: tick = (div_q == gct_pkg::INSTR_DIV_M1);
			default: tick = edge_rise & armed_q;
		endcase
	end
	assign ps_max = 3'((4'h1 << ctrl_q[gct_pkg::CTRL_PS_LO +: 2]) - 4'h1);
	assign pre_tick = enabled & tick;
	// Leftover count above a smaller ratio ends the period at once
	assign inc = pre_tick & (ps_q >= ps_max);

	// Bus decode
	assign wa = awaddr_q[13:2] == gct_pkg::ADDR_ASSIGN[13:2] ? gct_pkg::IDX_ASSIGN :
		{awaddr_q[11:2], 2'h0};
	assign ra = araddr_q[13:2] == gct_pkg::ADDR_ASSIGN[13:2] ? gct_pkg::IDX_ASSIGN :
		{araddr_q[11:2], 2'h0};
	assign wr_go = aw_have_q & w_have_q & ~s_bvalid_o;
	assign wb = wstrb_q[0] ? wdata_q[7:0] : 8'h00;
	assign wr_low = wr_go & wstrb_q[0] & (wa == gct_pkg::OFF_LOW);
	assign wr_high = wr_go & wstrb_q[0] & (wa == gct_pkg::OFF_HIGH);
	assign rd_go = s_arready_o == 1'b0 && s_rvalid_o == 1'b0 && araddr_q != 14'h3fff;
	assign rd_low = rd_go & (ra == gct_pkg::OFF_LOW);
	assign ok_w = wa == gct_pkg::OFF_CTRL || wa == gct_pkg::OFF_GATE || wa == gct_pkg::OFF_LOW
		|| wa == gct_pkg::OFF_HIGH || wa == gct_pkg::IDX_ASSIGN || wa == gct_pkg::OFF_MODE
		|| wa == gct_pkg::OFF_FLAG;
	assign ok_r = ra == gct_pkg::OFF_CTRL || ra == gct_pkg::OFF_GATE || ra == gct_pkg::OFF_LOW
		|| ra == gct_pkg::OFF_HIGH || ra == gct_pkg::IDX_ASSIGN || ra == gct_pkg::OFF_MODE
		|| ra == gct_pkg::OFF_FLAG;

	always_comb begin
		rbyte = 8'h00;
		unique case (ra)
			gct_pkg::OFF_CTRL: rbyte = ctrl_q;
			gct_pkg::OFF_GATE: rbyte = gate_q;
			gct_pkg::OFF_LOW: rbyte = cnt_q[7:0];
			// Wide mode exposes only the buffer
			gct_pkg::OFF_HIGH: rbyte = ctrl_q[gct_pkg::CTRL_WIDE] ? hbuf_q : cnt_q[15:8];
			// Flag bit 4, field bits 1:0, rest zero
			gct_pkg::IDX_ASSIGN: rbyte = {3'h0, pm_q != gct_pkg::PM_RUN, 2'h0, assign_q};
			gct_pkg::OFF_MODE: rbyte = {3'h0, mode_q};
			gct_pkg::OFF_FLAG: rbyte = {6'h0, ovf_en_q, ovf_q};
			default: rbyte = 8'h00;
		endcase
	end

	// AXI write channel
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 14'h0000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_bvalid_o <= 1'b0;
			s_bresp_o <= gct_pkg::AXI_OKAY;
		end else begin
			if (s_awvalid_i && s_awready_o) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_awaddr_i;
			end
			if (s_wvalid_i && s_wready_o) begin
				w_have_q <= 1'b1;
				wdata_q <= s_wdata_i;
				wstrb_q <= s_wstrb_i;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_bvalid_o <= 1'b1;
				s_bresp_o <= ok_w ? gct_pkg::AXI_OKAY : gct_pkg::AXI_SLVERR;
			end else if (s_bready_i) begin
				s_bvalid_o <= 1'b0;
			end
		end
	end
	assign s_awready_o = ~aw_have_q & ~s_bvalid_o;
	assign s_wready_o = ~w_have_q & ~s_bvalid_o;

	// AXI read channel, araddr all-ones marks idle
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			araddr_q <= 14'h3fff;
			s_arready_o <= 1'b1;
			s_rvalid_o <= 1'b0;
			s_rdata_o <= 32'h00000000;
			s_rresp_o <= gct_pkg::AXI_OKAY;
		end else begin
			if (s_arvalid_i && s_arready_o) begin
				araddr_q <= s_araddr_i;
				s_arready_o <= 1'b0;
			end
			if (rd_go) begin
				s_rvalid_o <= 1'b1;
				s_rdata_o <= {24'h000000, rbyte};
				s_rresp_o <= ok_r ? gct_pkg::AXI_OKAY : gct_pkg::AXI_SLVERR;
			end else if (s_rvalid_o && s_rready_i) begin
				s_rvalid_o <= 1'b0;
				s_arready_o <= 1'b1;
				araddr_q <= 14'h3fff;
			end
		end
	end

	// Control registers
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ctrl_q <= gct_pkg::CTRL_RESET;
			gate_q <= gct_pkg::GATE_RESET;
			assign_q <= 2'h0;
			mode_q <= 5'h00;
		end else if (wr_go && wstrb_q[0]) begin
			if (wa == gct_pkg::OFF_CTRL)
				ctrl_q <= wb;
			if (wa == gct_pkg::OFF_GATE)
				gate_q <= wb;
			if (wa == gct_pkg::IDX_ASSIGN)
				assign_q <= wb[1:0] & gct_pkg::ASSIGN_MASK[1:0];
			if (wa == gct_pkg::OFF_MODE)
				mode_q <= wb[4:0];
		end
	end

	// Edge history and instruction divider
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ext_q <= 1'b0;
			ext_sync_q <= 1'b0;
			div_q <= 2'h0;
		end else begin
			ext_q <= src_in;
			ext_sync_q <= ext_q;
			div_q <= div_q + 2'h1;
		end
	end

	// First rising edge needs a falling edge first
	always_ff @(posedge clock_i) begin
		if (srst_i)
			armed_q <= 1'b0;
		else if (wr_low || wr_high || !enabled)
			armed_q <= 1'b0;
		else if (edge_fall)
			armed_q <= 1'b1;
	end

	// Prescaler, cleared by low byte writes and by high byte writes outside wide mode
	always_ff @(posedge clock_i) begin
		if (srst_i)
			ps_q <= 3'h0;
		else if (wr_low || (wr_high && !ctrl_q[gct_pkg::CTRL_WIDE]))
			ps_q <= 3'h0;
		else if (pre_tick)
			ps_q <= (ps_q >= ps_max) ? 3'h0 : ps_q + 3'h1;
	end

	// Count, write wins over increment; holds while off
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			cnt_q <= 16'h0000;
			hbuf_q <= 8'h00;
		end else begin
			if (rd_low && ctrl_q[gct_pkg::CTRL_WIDE])
				hbuf_q <= cnt_q[15:8];
			if (wr_low) begin
				cnt_q[7:0] <= wb;
				if (ctrl_q[gct_pkg::CTRL_WIDE])
					cnt_q[15:8] <= hbuf_q;
			end else if (wr_high) begin
				if (ctrl_q[gct_pkg::CTRL_WIDE])
					hbuf_q <= wb;
				else
					cnt_q[15:8] <= wb;
			end else if (inc) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	// Overflow flag, set wins over clear
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ovf_q <= 1'b0;
			ovf_en_q <= 1'b0;
		end else begin
			if (wr_go && wstrb_q[0] && wa == gct_pkg::OFF_FLAG) begin
				ovf_q <= wb[0];
				ovf_en_q <= wb[1];
			end
			if (inc && !wr_low && !wr_high && cnt_q == 16'hffff)
				ovf_q <= 1'b1;
		end
	end

	// Power mode sequencing
	always_ff @(posedge clock_i) begin
		if (srst_i)
			pm_q <= gct_pkg::PM_RUN;
		else begin
			unique case (pm_q)
				gct_pkg::PM_RUN: if (mode_q[gct_pkg::MODE_SCS_LO +: 2] == gct_pkg::SCS_SECONDARY)
					pm_q <= gct_pkg::PM_SECONDARY_RUN_MODE;
				gct_pkg::PM_SECONDARY_RUN_MODE: begin
					if (mode_q[gct_pkg::MODE_SCS_LO +: 2] != gct_pkg::SCS_SECONDARY)
						pm_q <= gct_pkg::PM_RUN;
					else if ((sleep_i || mode_q[gct_pkg::MODE_SLEEP]) && !mode_q[gct_pkg::MODE_IDLE])
						pm_q <= gct_pkg::PM_SECONDARY_IDLE_MODE;
				end
				gct_pkg::PM_SECONDARY_IDLE_MODE: if (mode_q[gct_pkg::MODE_SCS_LO +: 2] != gct_pkg::SCS_SECONDARY)
					pm_q <= gct_pkg::PM_RUN;
				default: pm_q <= gct_pkg::PM_RUN;
			endcase
		end
	end

	// Registered outputs
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			port_read_o <= 2'h0;
			pin_oe_n_o <= 2'h3;
			crystal_run_o <= 1'b0;
			osc_drive_level_o <= 1'b0;
			overflow_irq_o <= 1'b0;
			power_mode_o <= 3'h1;
			route_unit_o <= 2'h3;
			count_o <= 16'h0000;
		end else begin
			port_read_o <= enabled ? 2'h0 : port_pin_i;
			pin_oe_n_o <= enabled ? 2'h3 : port_c_direction_i;
			// Runs regardless of power mode
			crystal_run_o <= ctrl_q[gct_pkg::CTRL_XTAL];
			osc_drive_level_o <= mode_q[gct_pkg::MODE_DRIVE];
			overflow_irq_o <= ovf_q & ovf_en_q;
			power_mode_o <= pm_q;
			// Unit one in the upper bit, as assign_route_t orders it
			route_unit_o <= {assign_q != 2'h2, assign_q == 2'h0};
			count_o <= cnt_q;
		end
	end

	a_flag_wait: assert property (@(posedge clock_i) disable iff (srst_i)
		(wr_low && enabled && ext_sel) |=> !armed_q)
		else $error("count armed right after low write");
	a_ovf_latch: assert property (@(posedge clock_i) disable iff (srst_i)
		(inc && !wr_low && !wr_high && cnt_q == 16'hffff) |=> (ovf_q && cnt_q == 16'h0000))
		else $error("overflow not latched on rollover");
	a_hold_off: assert property (@(posedge clock_i) disable iff (srst_i)
		(!enabled && !wr_low && !wr_high) |=> cnt_q == $past(cnt_q))
		else $error("count moved while disabled");
	a_wide_load: assert property (@(posedge clock_i) disable iff (srst_i)
		(wr_low && ctrl_q[gct_pkg::CTRL_WIDE]) |=> cnt_q[15:8] == $past(hbuf_q))
		else $error("high byte not loaded from buffer");
	a_buf_read: assert property (@(posedge clock_i) disable iff (srst_i)
		(rd_low && ctrl_q[gct_pkg::CTRL_WIDE]) |=> hbuf_q == $past(cnt_q[15:8]))
		else $error("buffer not loaded on low read");
	a_ps_keep: assert property (@(posedge clock_i) disable iff (srst_i)
		(wr_high && ctrl_q[gct_pkg::CTRL_WIDE] && !pre_tick) |=> ps_q == $past(ps_q))
		else $error("prescaler changed by buffer write");
	a_pins_in: assert property (@(posedge clock_i) disable iff (srst_i)
		enabled |=> (pin_oe_n_o == 2'h3 && port_read_o == 2'h0))
		else $error("pins not forced to input");
	a_need_both: assert property (@(posedge clock_i) disable iff (srst_i)
		inc |-> (ctrl_q[gct_pkg::CTRL_ON] && gate_q[gct_pkg::GATE_EN]))
		else $error("count without both enables");
	a_sys_rate: assert property (@(posedge clock_i) disable iff (srst_i)
		(enabled && cs == gct_pkg::CS_SYS && ctrl_q[5:4] == 2'h0 && !wr_go) |-> inc)
		else $error("system clock did not advance count");
	a_instr_rate: assert property (@(posedge clock_i) disable iff (srst_i)
		(cs == gct_pkg::CS_INSTR && inc) |-> div_q == 2'h3)
		else $error("instruction tick off cycle");
	a_secondary_run_mode: assert property (@(posedge clock_i) disable iff (srst_i)
		(pm_q == gct_pkg::PM_RUN && mode_q[1:0] == gct_pkg::SCS_SECONDARY) |=> pm_q == gct_pkg::PM_SECONDARY_RUN_MODE)
		else $error("secondary run not entered");
endmodule
`default_nettype wire

/* testbench/ext_source.sv */
// Purpose: Far-side model driving the external count line
// Assumes: Edges are placed just after rising clock edges
// Notes: Lines hold their level between pulses; no free-running clock
`timescale 1ns/1ns
`default_nettype none
module ext_source (
	// Clock
	input wire logic clock_i,
	// Count lines
	output logic ext_count_o,
	output logic crystal_clk_o
);
	initial ext_count_o = 1'b0;
	initial crystal_clk_o = 1'b0;
	// Separate lines, so a wrong source choice leaves the count still
	// Each pulse is a rising then a falling edge, wide enough to sync
	task automatic pulse(input int n, input bit on_xtal);
		repeat (n) begin
			@(posedge clock_i);
			if (on_xtal) crystal_clk_o <= 1'b1;
			else ext_count_o <= 1'b1;
			repeat (4) @(posedge clock_i);
			if (on_xtal) crystal_clk_o <= 1'b0;
			else ext_count_o <= 1'b0;
			repeat (3) @(posedge clock_i);
		end
	endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: Self-checking bench for the gated count timer
// Assumes: AXI4-Lite master tasks; byte data in bits 7:0
// Notes: Rate checks span whole tick periods, so phase does not matter
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [13:0] A_CTRL = {2'b00, gct_pkg::OFF_CTRL};
	localparam logic [13:0] A_GATE = {2'b00, gct_pkg::OFF_GATE};
	localparam logic [13:0] A_LOW = {2'b00, gct_pkg::OFF_LOW};
	localparam logic [13:0] A_HIGH = {2'b00, gct_pkg::OFF_HIGH};
	localparam logic [13:0] A_MODE = {2'b00, gct_pkg::OFF_MODE};
	localparam logic [13:0] A_FLAG = {2'b00, gct_pkg::OFF_FLAG};
	localparam logic [13:0] A_ASG = gct_pkg::ADDR_ASSIGN;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic [13:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic sleep = 1'b0;
	logic [31:0] wdata = '0, rdata, rd;
	logic ext, xtal, awready, wready, bvalid, arready, rvalid, drive, irq, xrun;
	logic [1:0] bresp, rresp, resp, pread, oen, route;
	logic [2:0] pmode;
	logic [15:0] cnt;
	int fail_count = 0, n_checks = 0;
	always #10 clock_i = ~clock_i;
	gated_count_timer_core i_dut (
		.clock_i(clock_i), .srst_i(srst_i),
		.s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
		.s_wdata_i(wdata), .s_wstrb_i(4'hf), .s_wvalid_i(wvalid), .s_wready_o(wready),
		.s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
		.s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
		.s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready),
		.ext_count_i(ext), .crystal_clk_i(xtal), .port_pin_i(2'h3),
		.port_c_direction_i(2'h0), .sleep_i(sleep), .port_read_o(pread),
		.pin_oe_n_o(oen), .crystal_run_o(xrun), .osc_drive_level_o(drive),
		.overflow_irq_o(irq), .power_mode_o(pmode), .route_unit_o(route), .count_o(cnt)
	);
	ext_source i_src (.clock_i(clock_i), .ext_count_o(ext), .crystal_clk_o(xtal));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic hang;
		chk(32'h0, 32'h1);
		print_verdict();
	endtask
	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		int n;
		@(posedge clock_i);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		resp = bresp;
		bready <= 1'b0;
		if (n == 50) hang();
	endtask
	task automatic rdr(input logic [13:0] a);
		int n;
		@(posedge clock_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock_i);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n == 50) hang();
	endtask
	task automatic t_power;
		wr(A_CTRL, 8'h08);
		// No ready flag exists, so give the crystal time to start
		repeat (20) @(posedge clock_i);
		chk(xrun, 1'b1);
		wr(A_MODE, 8'h08);
		repeat (2) @(posedge clock_i);
		chk(drive, 1'b1);
		wr(A_MODE, 8'h09);
		repeat (2) @(posedge clock_i);
		chk(pmode, 3'b010);
		rdr(A_ASG);
		chk(rd, 32'h10);
		sleep <= 1'b1;
		repeat (3) @(posedge clock_i);
		chk(pmode, 3'b100);
		chk(xrun, 1'b1);
		sleep <= 1'b0;
		wr(A_MODE, 8'h00);
	endtask
	task automatic t_assign;
		for (int f = 0; f < 3; f++) begin
			wr(A_ASG, {6'h3f, f[1:0]});
			rdr(A_ASG);
			chk(rd, f);
			chk(route, {f != 2, f == 0});
		end
		wr(14'h0100, 8'h55);
		chk(resp, gct_pkg::AXI_SLVERR);
		rdr(14'h0100);
		chk(resp, gct_pkg::AXI_SLVERR);
	endtask
	task automatic t_rate;
		logic [15:0] c0;
		wr(A_GATE, 8'h80);
		for (int cs = 0; cs < 2; cs++) for (int p = 0; p < 4; p++) begin
			// Sync bit set on purpose: it must not matter here
			wr(A_CTRL, {cs[1:0], p[1:0], 4'h5});
			repeat (40) @(posedge clock_i);
			c0 = cnt;
			repeat ((cs == 1 ? 8 : 32) << p) @(posedge clock_i);
			chk(16'(cnt - c0), 32'd8);
		end
		wr(A_GATE, 8'h00);
		repeat (2) @(posedge clock_i);
		c0 = cnt;
		repeat (20) @(posedge clock_i);
		chk(cnt, c0);
		wr(A_CTRL, 8'h00);
	endtask
	task automatic t_counter;
		for (int s = 0; s < 3; s++) begin
			wr(A_GATE, 8'h80);
			wr(A_LOW, 8'h00);
			wr(A_HIGH, 8'h00);
			// Third pass counts the crystal line while the pin stays idle
			wr(A_CTRL, {4'h8, s == 2, s[0], 2'b01});
			i_src.pulse(3, s == 2);
			repeat (4) @(posedge clock_i);
			chk(cnt, 16'h0002);
			chk(pread, 2'b00);
			chk(oen, 2'b11);
			wr(A_CTRL, 8'h80);
			i_src.pulse(2, s == 2);
			chk(cnt, 16'h0002);
			chk(pread, 2'b11);
			chk(oen, 2'b00);
			rdr(A_LOW);
			chk(rd, 32'h2);
		end
	endtask
	task automatic t_wide;
		wr(A_FLAG, 8'h02);
		wr(A_CTRL, 8'h42);
		wr(A_HIGH, 8'hff);
		// Count output is registered, one edge behind the count
		@(posedge clock_i);
		chk(cnt, 16'h0002);
		wr(A_LOW, 8'hfe);
		@(posedge clock_i);
		chk(cnt, 16'hfffe);
		wr(A_CTRL, 8'h43);
		repeat (6) @(posedge clock_i);
		wr(A_CTRL, 8'h42);
		chk(irq, 1'b1);
		chk(cnt[15:8], 8'h00);
		rdr(A_HIGH);
		chk(rd, 32'hff);
		rdr(A_LOW);
		rdr(A_HIGH);
		chk(rd, 32'h00);
		wr(A_FLAG, 8'h00);
		repeat (2) @(posedge clock_i);
		chk(irq, 1'b0);
		wr(A_CTRL, 8'h00);
	endtask
	initial begin
		repeat (5) @(posedge clock_i);
		srst_i <= 1'b0;
		t_power();
		t_assign();
		t_rate();
		t_counter();
		t_wide();
		print_verdict();
	end
endmodule
`default_nettype wire
